// [tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, send = 1'b0, hread = 1'b0;
    logic        mdrop = 1'b0, rx_dma = 1'b0, tx_dma = 1'b0, full = 1'b0, busy = 1'b0;
    logic        brk = 1'b0, irq, wait_rq, c_done, b_evt, s_low, p_bad, p_high, tick;
    logic        rx_on, tx_on, brk_rq;
    logic [2:0]  kind = 3'h0;
    logic [5:0]  addr = 6'h00;
    logic [31:0] wdata = 32'h0, rdata;
    int          miscompares = 0, n_tests = 0;
    logic [5:0]  t_addr [12] = '{6'h08, 6'h0c, 6'h0c, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h3c,
                                 6'h0c, 6'h08, 6'h0c, 6'h08};
    logic [31:0] t_data [12] = '{32'h3ff, 32'h001, 32'h000, 32'h000, 32'h200, 32'h3ff,
                                 32'h3ff, 32'h3ff, 32'h3ff, 32'h155, 32'h100, 32'h2aa};
    logic [31:0] t_exp  [12] = '{32'h3ff, 32'h3fe, 32'h3fe, 32'h3fe, 32'h1fe, 32'h1fe,
                                 32'h1fe, 32'h1fe, 32'h000, 32'h155, 32'h055, 32'h2ff};
    // plain high parity bit goes first, while the parity flag is still clear
    logic [2:0]  e_kind [4]  = '{3'h3, 3'h1, 3'h2, 3'h4};
    logic [31:0] e_exp  [4]  = '{32'h020, 32'h060, 32'h0e0, 32'h0e4};

    always #5 clk = ~clk;

    usis_irq_status usis_irq_status_i (.i_ref_clk(clk), .i_rst_b(rst_b), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq), .i_rx_char_done(c_done),
        .i_rx_holding_read(hread), .i_rx_break_evt(b_evt), .i_rx_stop_low(s_low),
        .i_rx_parity_bad(p_bad), .i_rx_parity_high(p_high), .i_multidrop(mdrop),
        .i_rx_dma_done(rx_dma), .i_tx_dma_done(tx_dma), .i_tx_holding_full(full),
        .i_tx_shift_busy(busy), .i_tx_break_active(brk), .i_bit_tick(tick),
        .o_rx_enabled(rx_on), .o_tx_enabled(tx_on), .o_break_req(brk_rq), .o_irq(irq));

    usis_line_model usis_line_model_i (.i_ref_clk(clk), .i_rst_b(rst_b), .i_send(send),
        .i_kind(kind), .o_char_done(c_done), .o_break_evt(b_evt), .o_stop_low(s_low),
        .o_parity_bad(p_bad), .o_parity_high(p_high), .o_bit_tick(tick));

    ////////////////////////////////////////////////////////////////////////////////
    // verdict in one place, also reached by a hung bus wait
    task automatic summarize();
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // request held until waitrequest is sampled low; data taken at that edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n = 0;
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wait_rq !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            summarize();
        end
    endtask

    task automatic put(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic get(input string nm, input logic [5:0] a, input logic [31:0] e,
                       input logic [31:0] m = 32'hffffffff);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q & m);
    endtask

    task automatic line(input logic [2:0] k);
        @(posedge clk);
        send <= 1'b1;
        kind <= k;
        @(posedge clk);
        send <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: table of mask writes, then hand-written cases
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        get("mask_rst", 6'h10, 32'h0);
        get("stat_rst", 6'h14, 32'h0);
        for (int i = 0; i < 12; i++) begin
            put(t_addr[i], t_data[i]);
            get("mask_tbl", 6'h10, t_exp[i]);
        end
        put(6'h0c, 32'h3ff);
        put(6'h00, 32'h40);
        get("tx_en", 6'h14, 32'h202);
        chk("tx_on", 32'h1, {31'h0, tx_on});
        full <= 1'b1;
        get("tx_full", 6'h14, 32'h0);
        full <= 1'b0;
        busy <= 1'b1;
        get("tx_shift", 6'h14, 32'h002);
        busy <= 1'b0;
        put(6'h00, 32'h200);
        get("brk_pend", 6'h14, 32'h200);
        chk("brk_req_on", 32'h1, {31'h0, brk_rq});
        brk <= 1'b1;
        get("brk_act", 6'h14, 32'h0, 32'h200);
        chk("brk_req_off", 32'h0, {31'h0, brk_rq});
        brk <= 1'b0;
        get("brk_done", 6'h14, 32'h202);
        put(6'h00, 32'h80);
        get("tx_dis", 6'h14, 32'h0);
        chk("tx_off", 32'h0, {31'h0, tx_on});
        rx_dma <= 1'b1;
        tx_dma <= 1'b1;
        get("dma_both", 6'h14, 32'h018);
        rx_dma <= 1'b0;
        get("dma_tx", 6'h14, 32'h010);
        tx_dma <= 1'b0;
        put(6'h00, 32'h10);
        line(3'h0);
        get("rx_rdy", 6'h14, 32'h001);
        chk("rx_on", 32'h1, {31'h0, rx_on});
        line(3'h0);
        get("overrun", 6'h14, 32'h021);
        @(posedge clk);
        hread <= 1'b1;
        @(posedge clk);
        hread <= 1'b0;
        get("rx_read", 6'h14, 32'h020);
        get("no_side", 6'h14, 32'h020);
        for (int i = 0; i < 4; i++) begin
            line(e_kind[i]);
            get("err_flag", 6'h14, e_exp[i]);
        end
        put(6'h08, 32'h040);
        repeat (2) @(posedge clk);
        chk("irq_on", 32'h1, {31'h0, irq});
        put(6'h0c, 32'h040);
        repeat (2) @(posedge clk);
        chk("irq_off", 32'h0, {31'h0, irq});
        put(6'h00, 32'h100);
        get("stat_clr", 6'h14, 32'h0);
        mdrop <= 1'b1;
        line(3'h3);
        get("mdrop_par", 6'h14, 32'h080);
        mdrop <= 1'b0;
        line(3'h0);
        put(6'h00, 32'h20);
        get("rx_dis", 6'h14, 32'h0, 32'h001);
        chk("rx_off", 32'h0, {31'h0, rx_on});
        put(6'h00, 32'h10);
        put(6'h24, 32'h1);
        repeat (40) @(posedge clk);
        get("to_wait", 6'h14, 32'h0, 32'h100);
        line(3'h0);
        repeat (30) @(posedge clk);
        get("to_fire", 6'h14, 32'h100, 32'h100);
        put(6'h24, 32'h0);
        get("to_off", 6'h14, 32'h0, 32'h100);
        put(6'h08, 32'h3ff);
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        get("mask_rst2", 6'h10, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire

// [usis_irq_status.sv]
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module usis_irq_status (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_b,
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_rx_char_done,
    input  wire logic        i_rx_holding_read,
    input  wire logic        i_rx_break_evt,
    input  wire logic        i_rx_stop_low,
    input  wire logic        i_rx_parity_bad,
    input  wire logic        i_rx_parity_high,
    input  wire logic        i_multidrop,
    input  wire logic        i_rx_dma_done,
    input  wire logic        i_tx_dma_done,
    input  wire logic        i_tx_holding_full,
    input  wire logic        i_tx_shift_busy,
    input  wire logic        i_tx_break_active,
    input  wire logic        i_bit_tick,
    output logic             o_rx_enabled,
    output logic             o_tx_enabled,
    output logic             o_break_req,
    output logic             o_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [9:0]              mask;
        logic                    rx_rdy;
        logic                    brk;
        logic                    ovr;
        logic                    frm;
        logic                    par;
        logic                    tmo;
        logic                    rx_en;
        logic                    tx_en;
        logic                    brk_pend;
        logic [7:0]              to_val;
        logic [9:0]              to_cnt;
        usis_pkg::usis_to_state_t to_st;
        logic                    ack;
        logic                    irq;
        logic [31:0]             rdata;
    } usis_state_t;

    usis_state_t st_r;
    usis_state_t st_nxt;

    logic        req;
    logic        wr_go;
    logic [31:0] be_mask;
    logic [31:0] wdata;
    logic [9:0]  csr;
    logic        cmd_wr;
    logic        stat_clr;
    logic        arm;

    // counter width, declared ahead of the load casts that use it
    localparam int TO_CNT_W = usis_pkg::TO_CNT_W;

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    // byte lanes gate write data per lane
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign be_mask[gi*8 +: 8] = {8{i_avs_byteenable[gi]}};
        end
    endgenerate

    // every access answers on the second edge; waitrequest drops once ack is up
    assign req               = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~st_r.ack;
    assign wr_go             = i_avs_write & st_r.ack;
    assign wdata             = i_avs_writedata & be_mask;
    assign cmd_wr            = wr_go & (i_avs_address == usis_pkg::OFS_COMMAND);
    assign stat_clr          = cmd_wr & wdata[usis_pkg::CMD_STAT_CLR];
    // writing the time-out value arms the timer as well
    assign arm = (cmd_wr & wdata[usis_pkg::CMD_ARM_IDLE])
               | (wr_go & (i_avs_address == usis_pkg::OFS_TIMEOUT));

    ////////////////////////////////////////////////////////////////////////////////
    // live status word, same layout as mask

    always_comb begin
        csr                          = '0;
        csr[usis_pkg::BIT_RX_RDY]    = st_r.rx_rdy;
        csr[usis_pkg::BIT_TX_FREE]   = st_r.tx_en & ~i_tx_holding_full
                                     & ~st_r.brk_pend;                     // R5 R6
        csr[usis_pkg::BIT_BREAK]     = st_r.brk;
        csr[usis_pkg::BIT_RX_DMA]    = i_rx_dma_done;                      // R8
        csr[usis_pkg::BIT_TX_DMA]    = i_tx_dma_done;                      // R9
        csr[usis_pkg::BIT_OVERRUN]   = st_r.ovr;
        csr[usis_pkg::BIT_FRAME]     = st_r.frm;
        csr[usis_pkg::BIT_PARITY]    = st_r.par;
        csr[usis_pkg::BIT_TIMEOUT]   = st_r.tmo;
        csr[usis_pkg::BIT_TX_EMPTY]  = st_r.tx_en & ~i_tx_holding_full
                                     & ~i_tx_shift_busy & ~i_tx_break_active; // R14 R6 R2
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt     = st_r;
        st_nxt.ack = req & ~st_r.ack;

        // mask: enable sets, disable clears, one-bits only
        if (wr_go && i_avs_address == usis_pkg::OFS_IRQ_EN) begin
            st_nxt.mask = st_r.mask | wdata[9:0];                          // R16
        end
        if (wr_go && i_avs_address == usis_pkg::OFS_IRQ_DIS) begin
            st_nxt.mask = st_r.mask & ~wdata[9:0];                         // R1
        end
        if (wr_go && i_avs_address == usis_pkg::OFS_TIMEOUT) begin
            st_nxt.to_val = wdata[7:0];
        end

        // enables; disable wins if both bits written together
        if (cmd_wr && wdata[usis_pkg::CMD_RX_EN]) begin
            st_nxt.rx_en = 1'b1;
        end
        if (cmd_wr && wdata[usis_pkg::CMD_RX_DIS]) begin
            st_nxt.rx_en = 1'b0;
        end
        if (cmd_wr && wdata[usis_pkg::CMD_TX_EN]) begin
            st_nxt.tx_en = 1'b1;                                           // R6
        end
        if (cmd_wr && wdata[usis_pkg::CMD_TX_DIS]) begin
            st_nxt.tx_en = 1'b0;
        end

        // break request stays pending until the break actually starts or transmit is disabled
        if (i_tx_break_active || !st_nxt.tx_en) begin
            st_nxt.brk_pend = 1'b0;
        end else if (cmd_wr && wdata[usis_pkg::CMD_BRK_START]) begin
            st_nxt.brk_pend = 1'b1;                                        // R5
        end

        // receive ready: holding read or disable clears, new character sets
        if (i_rx_holding_read || !st_nxt.rx_en) begin
            st_nxt.rx_rdy = 1'b0;                                          // R4
        end
        if (i_rx_char_done && st_nxt.rx_en) begin
            st_nxt.rx_rdy = 1'b1;                                          // R4
        end

        // sticky errors: clear first so a same-cycle event wins
        if (stat_clr) begin
            st_nxt.brk = 1'b0;                                             // R15
            st_nxt.ovr = 1'b0;
            st_nxt.frm = 1'b0;
            st_nxt.par = 1'b0;
        end
        if (i_rx_break_evt) begin
            st_nxt.brk = 1'b1;                                             // R7
        end
        if (i_rx_char_done && st_r.rx_rdy) begin
            st_nxt.ovr = 1'b1;                                             // R10
        end
        if (i_rx_stop_low) begin
            st_nxt.frm = 1'b1;                                             // R11
        end
        if (i_rx_parity_bad || (i_multidrop && i_rx_parity_high)) begin
            st_nxt.par = 1'b1;                                             // R12
        end

        // idle timer; arming clears the flag and waits for a character
        if (arm) begin
            st_nxt.tmo = 1'b0;
            st_nxt.to_st = usis_pkg::USIS_TO_WAIT;                         // R17
        end else begin
            case (st_r.to_st)
                usis_pkg::USIS_TO_IDLE: begin
                    st_nxt.to_st = usis_pkg::USIS_TO_IDLE;
                end
                usis_pkg::USIS_TO_WAIT: begin
                    if (i_rx_char_done) begin
                        st_nxt.to_st  = usis_pkg::USIS_TO_COUNT;
                        st_nxt.to_cnt = TO_CNT_W'(st_r.to_val) * 10'(usis_pkg::TO_BITS_PER);
                    end
                end
                usis_pkg::USIS_TO_COUNT: begin
                    if (i_rx_char_done) begin
                        st_nxt.to_cnt = TO_CNT_W'(st_r.to_val) * 10'(usis_pkg::TO_BITS_PER);
                    end else if (i_bit_tick) begin
                        st_nxt.to_cnt = st_r.to_cnt - 10'h001;
                        if (st_r.to_cnt == 10'h001) begin
                            st_nxt.tmo   = 1'b1;                           // R13
                            st_nxt.to_st = usis_pkg::USIS_TO_IDLE;
                        end
                    end
                end
                default: begin
                    st_nxt.to_st = usis_pkg::USIS_TO_IDLE;
                end
            endcase
        end
        // a zero value disables the function entirely
        if (st_nxt.to_val == usis_pkg::TO_VAL_RST) begin
            st_nxt.to_st = usis_pkg::USIS_TO_IDLE;
            st_nxt.tmo   = 1'b0;                                           // R13
        end

        // read data latched when the request is taken; plain reads change nothing
        st_nxt.rdata = '0;                                                 // R19
        if (i_avs_read && !st_r.ack) begin
            case (i_avs_address)
                usis_pkg::OFS_IRQ_MASK: st_nxt.rdata = {22'h0, st_r.mask};  // R3
                usis_pkg::OFS_STATUS:   st_nxt.rdata = {22'h0, csr};
                usis_pkg::OFS_TIMEOUT:  st_nxt.rdata = {24'h0, st_r.to_val};
                default:                st_nxt.rdata = 32'h0;
            endcase
        end

        // registered interrupt avoids glitches from the live sources
        st_nxt.irq = |(csr & st_r.mask);                                   // R18
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r        <= '0;
            st_r.mask   <= usis_pkg::MASK_RST;                             // R3
            st_r.to_val <= usis_pkg::TO_VAL_RST;
            st_r.to_st  <= usis_pkg::USIS_TO_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_avs_readdata = st_r.rdata;
    assign o_rx_enabled   = st_r.rx_en;
    assign o_tx_enabled   = st_r.tx_en;
    assign o_break_req    = st_r.brk_pend;
    assign o_irq          = st_r.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    a_disable_clears_mask: assert property ( // R1
        wr_go && i_avs_address == usis_pkg::OFS_IRQ_DIS
        |=> (st_r.mask & $past(wdata[9:0])) == 10'h000)
        else $error("disable write left a mask bit set");

    a_enable_sets_mask: assert property ( // R16
        wr_go && i_avs_address == usis_pkg::OFS_IRQ_EN
        |=> (st_r.mask & $past(wdata[9:0])) == $past(wdata[9:0]))
        else $error("enable write did not set mask bit");

    a_mask_read_back: assert property ( // R3
        i_avs_read && !st_r.ack && i_avs_address == usis_pkg::OFS_IRQ_MASK
        |=> !o_avs_waitrequest && o_avs_readdata == {22'h0, $past(st_r.mask)})
        else $error("mask read returned wrong value");

    a_rx_ready_sets: assert property ( // R4
        i_rx_char_done && st_r.rx_en && !(cmd_wr && wdata[usis_pkg::CMD_RX_DIS])
        |=> csr[usis_pkg::BIT_RX_RDY])
        else $error("received character did not raise ready");

    a_rx_ready_disable: assert property ( // R4
        !st_r.rx_en |-> !csr[usis_pkg::BIT_RX_RDY])
        else $error("ready set while receiver disabled");

    a_tx_free_blocked: assert property ( // R5
        i_tx_holding_full || st_r.brk_pend |-> !csr[usis_pkg::BIT_TX_FREE])
        else $error("transmit ready while holding full or break pending");

    a_tx_enable_sets: assert property ( // R6
        cmd_wr && wdata[usis_pkg::CMD_TX_EN] && !wdata[usis_pkg::CMD_TX_DIS]
        ##1 !i_tx_holding_full && !i_tx_shift_busy && !i_tx_break_active && !st_r.brk_pend
        |-> csr[usis_pkg::BIT_TX_FREE] && csr[usis_pkg::BIT_TX_EMPTY])
        else $error("transmit enable did not raise ready and empty");

    a_break_sticky: assert property ( // R7
        st_r.brk && !stat_clr |=> st_r.brk)
        else $error("break flag dropped without status clear");

    a_dma_follow: assert property ( // R8 R9
        csr[usis_pkg::BIT_RX_DMA] == i_rx_dma_done && csr[usis_pkg::BIT_TX_DMA] == i_tx_dma_done)
        else $error("end-of-transfer flags not following sources");

    // a status clear one cycle later may legally drop the flag again
    a_overrun_sets: assert property ( // R10
        i_rx_char_done && st_r.rx_rdy |=> st_r.ovr ##1 (st_r.ovr || $past(stat_clr)))
        else $error("overrun not flagged or not held");

    a_frame_sets: assert property ( // R11
        i_rx_stop_low |=> st_r.frm ##1 (st_r.frm || $past(stat_clr)))
        else $error("framing error not flagged or not held");

    a_parity_sets: assert property ( // R12
        i_rx_parity_bad || (i_multidrop && i_rx_parity_high) |=> st_r.par)
        else $error("parity error not flagged");

    a_parity_plain_high: assert property ( // R12
        !st_r.par && i_rx_parity_high && !i_multidrop && !i_rx_parity_bad |=> !st_r.par)
        else $error("high parity bit flagged outside multi-drop mode");

    a_read_no_side: assert property ( // R19
        i_avs_read && !i_avs_write |=> st_r.mask == $past(st_r.mask))
        else $error("register read changed the mask");

    a_status_clear: assert property ( // R15
        stat_clr && !i_rx_break_evt && !i_rx_stop_low && !i_rx_parity_bad && !i_multidrop
        && !i_rx_char_done |=> !st_r.brk && !st_r.frm && !st_r.par && !st_r.ovr)
        else $error("status clear left an error flag set");

    a_timeout_zero: assert property ( // R13
        st_r.to_val == 8'h00 |-> !st_r.tmo && st_r.to_st == usis_pkg::USIS_TO_IDLE)
        else $error("time-out active with zero value");

    a_arm_waits: assert property ( // R17
        arm ##1 (st_r.to_val != 8'h00) |-> st_r.to_st == usis_pkg::USIS_TO_WAIT && !st_r.tmo)
        else $error("arming did not wait for a character");

    a_empty_drained: assert property ( // R14
        i_tx_holding_full || i_tx_shift_busy || i_tx_break_active
        |-> !csr[usis_pkg::BIT_TX_EMPTY])
        else $error("empty flag set while data or break in flight");

    a_irq_level: assert property ( // R18
        ##1 o_irq == $past(|(csr & st_r.mask)))
        else $error("interrupt output not matching masked status");

    c_overrun: cover property (st_r.rx_rdy && i_rx_char_done ##1 st_r.ovr);
    c_timeout: cover property (st_r.to_st == usis_pkg::USIS_TO_COUNT ##[1:200] st_r.tmo);
    c_irq_rise: cover property (!o_irq ##1 o_irq);
    c_mask_read: cover property (i_avs_read && i_avs_address == usis_pkg::OFS_IRQ_MASK
                                 ##1 !o_avs_waitrequest);

endmodule
`default_nettype wire

// [usis_line_model.sv]
`timescale 1ns/100ps
`default_nettype none
// far-side line model: turns a bench request into one-cycle receive event pulses
module usis_line_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_send,
    input  wire logic [2:0] i_kind,
    output logic            o_char_done,
    output logic            o_break_evt,
    output logic            o_stop_low,
    output logic            o_parity_bad,
    output logic            o_parity_high,
    output logic            o_bit_tick
);
    logic [1:0] tick_r;

    ////////////////////////////////////////////////////////////////////////////////
    // bit period of four clocks keeps time-out runs short
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_r        <= 2'h0;
            o_char_done   <= 1'b0;
            o_break_evt   <= 1'b0;
            o_stop_low    <= 1'b0;
            o_parity_bad  <= 1'b0;
            o_parity_high <= 1'b0;
        end else begin
            tick_r        <= tick_r + 2'h1;
            o_char_done   <= i_send && (i_kind == 3'h0);
            o_stop_low    <= i_send && (i_kind == 3'h1);
            o_parity_bad  <= i_send && (i_kind == 3'h2);
            o_parity_high <= i_send && (i_kind == 3'h3);
            o_break_evt   <= i_send && (i_kind == 3'h4);
        end
    end

    // tick is free running, as a baud generator would be
    assign o_bit_tick = (tick_r == 2'h3);
endmodule
`default_nettype wire

// [usis_pkg.sv]
// Notes on behaviour
// R1: writing one to an irq_disable bit clears that mask bit; zero leaves it.
// R2: ten sources share bit positions 0..9 in disable, mask and status.
// R3: irq_mask is read-only, resets to zero; one means source enabled.
// R4: rx_char_ready sets on a new character, clears on holding read or rx disable.
// R5: tx_holding_free is zero while holding register full or break start pending.
// R6: tx_holding_free and tx_fully_drained are zero at reset/disabled; tx enable sets them.
// R7: rx_break_seen sets on break or end of break, holds until status clear.
// R8: rx_dma_done follows the receive data-controller end-of-transfer signal.
// R9: tx_dma_done follows the transmit data-controller end-of-transfer signal.
// R10: rx_overrun_err sets when a character lands while rx_char_ready is set.
// R11: framing error sets on a low stop bit, holds until status clear.
// R12: parity_err sets on bad parity or high parity bit in multi-drop mode.
// R13: time-out sets when counter expires after arming; zero while value is zero.
// R14: tx_fully_drained is one only with holding and shift empty and no break.
// R15: status clear resets parity, framing, overrun and break flags.
// R16: writing one to an irq_enable bit sets that mask bit; zero leaves it.
// R17: arming the idle timer waits for a fresh character before counting.
// R18: interrupt output is high while any flag and its mask bit are both one.
// R19: reading mask or status has no side effect on flags or mask.
package usis_pkg;
    localparam int          ADDR_W        = 6;
    localparam int          NUM_SRC       = 10;
    // register byte offsets
    localparam logic [5:0]  OFS_COMMAND   = 6'h00;
    localparam logic [5:0]  OFS_IRQ_EN    = 6'h08;
    localparam logic [5:0]  OFS_IRQ_DIS   = 6'h0c;
    localparam logic [5:0]  OFS_IRQ_MASK  = 6'h10;
    localparam logic [5:0]  OFS_STATUS    = 6'h14;
    localparam logic [5:0]  OFS_TIMEOUT   = 6'h24;
    // status / mask bit positions
    localparam int          BIT_RX_RDY    = 0;
    localparam int          BIT_TX_FREE   = 1;
    localparam int          BIT_BREAK     = 2;
    localparam int          BIT_RX_DMA    = 3;
    localparam int          BIT_TX_DMA    = 4;
    localparam int          BIT_OVERRUN   = 5;
    localparam int          BIT_FRAME     = 6;
    localparam int          BIT_PARITY    = 7;
    localparam int          BIT_TIMEOUT   = 8;
    localparam int          BIT_TX_EMPTY  = 9;
    // command register bit positions
    localparam int          CMD_RX_EN     = 4;
    localparam int          CMD_RX_DIS    = 5;
    localparam int          CMD_TX_EN     = 6;
    localparam int          CMD_TX_DIS    = 7;
    localparam int          CMD_STAT_CLR  = 8;
    localparam int          CMD_BRK_START = 9;
    localparam int          CMD_ARM_IDLE  = 11;
    // reset values and time-out scaling
    localparam logic [9:0]  MASK_RST      = 10'h000;
    localparam logic [7:0]  TO_VAL_RST    = 8'h00;
    localparam int          TO_BITS_PER   = 4;
    localparam int          TO_CNT_W      = 10;

    typedef enum logic [1:0] {
        USIS_TO_IDLE  = 2'b00,
        USIS_TO_WAIT  = 2'b01,
        USIS_TO_COUNT = 2'b11
    } usis_to_state_t;
endpackage
